//--- bench/mdc_ctrl_checker.sv
// port assertions for the dac control front end
// assumes clk_i at 40 MHz and synchronous active low nrst_i
`timescale 1ns/1ps
module mdc_ctrl_checker (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic select_load_n_i,
  input wire logic sdo_oe_o,
  input wire logic async_update_n_i,
  input wire logic async_clear_n_i,
  input wire logic [mdc_pkg::TGP_N-1:0] toggle_dither_pin_i,
  input wire logic temp_over_i,
  input wire logic fault_oe_o,
  input wire logic [mdc_pkg::CHANNELS*mdc_pkg::CODE_W-1:0] dac_code_o,
  input wire logic [mdc_pkg::CHANNELS*mdc_pkg::SPAN_W-1:0] span_o,
  input wire logic mux_oe_o,
  input wire logic ref_int_en_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic irq_o
);
  import mdc_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  chk_sdo_released: assert property (select_load_n_i [*5] |-> !sdo_oe_o)
    else $error("sdo driven while select high");
  chk_clear_zero: assert property (!async_clear_n_i [*5] |-> dac_code_o == '0 && span_o == '0)
    else $error("clear did not zero codes and spans");
  chk_clear_ctrl: assert property (!async_clear_n_i [*5] |-> !mux_oe_o && ref_int_en_o)
    else $error("clear did not restore control defaults");
  chk_fault_heat: assert property (temp_over_i [*5] |-> fault_oe_o)
    else $error("fault not pulled on overtemperature");
  chk_ready_next: assert property (psel_i && !penable_i |=> pready_o)
    else $error("pready late");
  chk_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  chk_unmapped_err: assert property (psel_i && !penable_i && paddr_i > 8'h18 |=> pslverr_o)
    else $error("no error on unmapped address");
  chk_dac_quiet: assert property (($stable(toggle_dither_pin_i) && select_load_n_i &&
    async_update_n_i && async_clear_n_i) [*8] |-> $stable(dac_code_o))
    else $error("dac changed without a cause");
  cover property ($rose(select_load_n_i));
  cover property (irq_o);
  cover property (fault_oe_o);
endmodule

bind mdc_ctrl mdc_ctrl_checker chk (.clk_i, .nrst_i, .select_load_n_i, .sdo_oe_o,
  .async_update_n_i, .async_clear_n_i, .toggle_dither_pin_i, .temp_over_i, .fault_oe_o,
  .dac_code_o, .span_o, .mux_oe_o, .ref_int_en_o, .psel_i, .penable_i, .paddr_i,
  .pready_o, .pslverr_o, .irq_o);

//--- bench/mdc_host.sv
// serial master model standing on the far side of the dac link
// assumes the bench calls xfer; sck idles low between frames
`timescale 1ns/1ps
module mdc_host (
  output logic sck_o,
  output logic sdi_o,
  output logic cs_n_o,
  input wire logic sdo_i
);
  initial begin
    sck_o = 1'b0;
    sdi_o = 1'b0;
    cs_n_o = 1'b1;
  end
  // 200 ns link period, unrelated in phase to the system clock
  task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] rd);
    rd = '0;
    #37 cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_o = w[i];
      #100 sck_o = 1'b1;
      rd = {rd[30:0], sdo_i};
      #100 sck_o = 1'b0;
    end
    #100 cs_n_o = 1'b1;
    // released line: no stale level for the device to lean on
    sdi_o = ~sdi_o;
    #300;
  endtask
endmodule

//--- bench/testbench.sv
// self-checking bench for the dac control front end
// assumes mdc_host as serial master and an apb master task here
`timescale 1ns/1ps
module testbench;
  import mdc_pkg::*;
  typedef struct packed {
    logic [31:0] w;
    logic [5:0] n;
    logic [3:0] ch;
    logic [15:0] code;
  } mdc_row_t;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic upd_n = 1'b1;
  logic clr_n = 1'b1;
  logic temp = 1'b0;
  logic [2:0] tgp = 3'h0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, e, pslverr, pready, irq;
  logic sck, sdi, cs_n, sdo, sdo_oe, fault_oe, mux_oe, ref_en;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = '0, prd, q, rd, phase;
  logic [CHANNELS*CODE_W-1:0] dac;
  logic [CHANNELS*SPAN_W-1:0] span;
  logic [4:0] msel;
  logic [23:0] prev = '0;
  int bad_count = 0;
  int n_compared = 0;
  wire sdo_line = sdo_oe ? sdo : ~sdo;
  mdc_row_t rows [6] = '{
    '{32'h00031234, 6'd24, 4'h3, 16'h0000},
    '{32'h5a23abcd, 6'd32, 4'h3, 16'habcd},
    '{32'h00155555, 6'd24, 4'h5, 16'h0000},
    '{32'h00057777, 6'd24, 4'h5, 16'h0000},
    '{32'h00300000, 6'd32, 4'h5, 16'h7777},
    '{32'h0060ffff, 6'd24, 4'h0, 16'h0000}};
  always #12.5 clk_i = ~clk_i;
  mdc_ctrl uut (.clk_i, .nrst_i, .sck_i(sck), .sdi_i(sdi), .select_load_n_i(cs_n),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe), .async_update_n_i(upd_n), .async_clear_n_i(clr_n),
    .toggle_dither_pin_i(tgp), .temp_over_i(temp), .fault_o(), .fault_oe_o(fault_oe),
    .dac_code_o(dac), .span_o(span), .dither_phase_o(phase), .mux_sel_o(msel),
    .mux_oe_o(mux_oe), .ref_int_en_o(ref_en), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(pready),
    .pslverr_o(pslverr), .irq_o(irq));
  mdc_host host (.sck_o(sck), .sdi_o(sdi), .cs_n_o(cs_n), .sdo_i(sdo_line));
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // entered at a rising edge; the idle edge at the end avoids double drives
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    q = prd;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic cmd(input logic [31:0] w);
    host.xfer(w, 24, rd);
    @(posedge clk_i);
  endtask
  initial begin
    #600000;
    bad_count++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    chk({dac[31:0], sdo_oe, fault_oe, irq}, '0);
    repeat (3) @(posedge clk_i);
    apb(1'b1, ADDR_IRQ_EN, 32'h1);
    foreach (rows[i]) begin
      host.xfer(rows[i].w, rows[i].n, rd);
      chk(rd, {1'b0, 8'h00, prev[23:1]} >> (32 - rows[i].n));
      chk(dac[16*rows[i].ch +: 16], rows[i].code);
      prev = rows[i].w[23:0];
    end
    @(posedge clk_i);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk({irq, q}, {1'b1, 32'h3});
    apb(1'b1, ADDR_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    apb(1'b1, ADDR_IRQ_EN, 32'h1);
    apb(1'b1, ADDR_IRQ_CLR, 32'hf);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk({irq, q}, '0);
    apb(1'b1, ADDR_CTRL, 32'h8e);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk({msel, mux_oe, ref_en, q}, {5'h11, 2'b10, 32'h8e});
    apb(1'b0, 8'h40, 32'h0);
    chk({e, q}, {1'b1, 32'h0});
    temp <= 1'b1;
    repeat (6) @(posedge clk_i);
    temp <= 1'b0;
    chk(fault_oe, 1'b1);
    host.xfer(32'h00012345, 20, rd);
    chk(fault_oe, 1'b1);
    cmd(32'h00420003);
    chk({fault_oe, span[8:6]}, 4'h3);
    cmd(32'h00000f0f);
    upd_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(dac[15:0], 16'h0f0f);
    cmd(32'h00012222);
    chk(dac[31:16], 16'h2222);
    upd_n <= 1'b1;
    cmd(32'h00103333);
    apb(1'b1, ADDR_TGL_EN, 32'h1);
    tgp <= 3'h1;
    repeat (6) @(posedge clk_i);
    chk({dac[63:48], dac[15:0]}, 32'habcd3333);
    tgp <= 3'h0;
    repeat (6) @(posedge clk_i);
    chk(dac[15:0], 16'h0f0f);
    apb(1'b1, ADDR_CTRL, 32'h1);
    tgp <= 3'h1;
    repeat (6) @(posedge clk_i);
    chk({phase[7:6], phase[1:0]}, 4'h1);
    tgp <= 3'h0;
    apb(1'b1, ADDR_CTRL, 32'h6);
    clr_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk({dac[63:48], span[8:6], mux_oe, ref_en}, 21'h1);
    clr_n <= 1'b1;
    repeat (3) @(posedge clk_i);
    apb(1'b0, ADDR_TGL_EN, 32'h0);
    chk({sdo_oe, q}, '0);
    final_report();
  end
endmodule

//--- verilog/mdc_ctrl.sv
// digital control front end of a 16 channel voltage output dac
// assumes serial pins, update, clear and toggle pins are asynchronous
// and are oversampled by clk_i; link clock slower than clk_i / 4
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
module mdc_ctrl (
  input wire logic clk_i,
  input wire logic nrst_i,
  // serial link
  input wire logic sck_i,
  input wire logic sdi_i,
  input wire logic select_load_n_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  // asynchronous pins
  input wire logic async_update_n_i,
  input wire logic async_clear_n_i,
  input wire logic [mdc_pkg::TGP_N-1:0] toggle_dither_pin_i,
  input wire logic temp_over_i,
  output logic fault_o,
  output logic fault_oe_o,
  // analog side controls
  output logic [mdc_pkg::CHANNELS*mdc_pkg::CODE_W-1:0] dac_code_o,
  output logic [mdc_pkg::CHANNELS*mdc_pkg::SPAN_W-1:0] span_o,
  output logic [mdc_pkg::CHANNELS*mdc_pkg::PHASE_W-1:0] dither_phase_o,
  output logic [mdc_pkg::MUX_W-1:0] mux_sel_o,
  output logic mux_oe_o,
  output logic ref_int_en_o,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o
);
  import mdc_pkg::*;

  localparam logic [SYNC_N-1:0] SYNC_INIT = 9'h01c;

  logic [SYNC_N-1:0] pins_s;
  logic sck_q_ff, cs_q_ff, async_update_n_q_ff;
  logic [TGP_N-1:0] tgp_q_ff;
  logic [SR_W-1:0] sr_ff, tx_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [23:0] last_word_ff;
  logic upd_pend_ff;
  logic sdo_ff, sdo_oe_ff, fault_ff;
  logic [CTRL_W-1:0] ctrl_ff;
  logic [CHANNELS-1:0] tgl_en_ff;
  logic [IRQ_W-1:0] irq_stat_ff, irq_en_ff;
  logic irq_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;
  logic [CODE_W-1:0] in_a_ff [CHANNELS];
  logic [CODE_W-1:0] in_b_ff [CHANNELS];
  logic [CODE_W-1:0] dac_ff [CHANNELS];
  logic [SPAN_W-1:0] span_ff [CHANNELS];
  logic [PHASE_W-1:0] phase_ff [CHANNELS];

  mdc_sync #(
    .W(SYNC_N),
    .INIT(SYNC_INIT)
  ) u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i({toggle_dither_pin_i, temp_over_i, async_clear_n_i, async_update_n_i,
              select_load_n_i, sdi_i, sck_i}),
    .sync_o(pins_s)
  );

  wire sck_s = pins_s[S_SCK];
  wire sdi_s = pins_s[S_SDI];
  wire cs_s = pins_s[S_CS];
  wire async_update_n_s = pins_s[S_ASYNC_UPDATE_N];
  wire clr_act = !pins_s[S_CLR];
  wire temp_s = pins_s[S_TEMP];
  wire [TGP_N-1:0] tgp_s = pins_s[S_TGP +: TGP_N];
  // clear acts like reset for serial, channel and control registers; irq status, apb and edge flops reset only on nrst_i
  wire soft_rst = !nrst_i || clr_act;

  // edge detection on the synchronised pins
  wire cs_fall = cs_q_ff && !cs_s;
  wire cs_rise = !cs_q_ff && cs_s;
  wire sck_rise = !sck_q_ff && sck_s && !cs_s;
  wire sck_fall = sck_q_ff && !sck_s && !cs_s;
  wire async_update_n_fall = async_update_n_q_ff && !async_update_n_s;
  wire [TGP_N-1:0] tgp_rise = tgp_s & ~tgp_q_ff;
  wire [TGP_N-1:0] tgp_fall = ~tgp_s & tgp_q_ff;

  wire word_ok = (cnt_ff == WORD_SHORT) || (cnt_ff == WORD_LONG);
  wire exec = cs_rise && word_ok;
  wire word_err = cs_rise && !word_ok;
  // 32 bit words carry 8 leading padding bits
  wire [23:0] cmd_word = sr_ff[23:0];
  wire [3:0] opcode = cmd_word[CMD_HI:CMD_LO];
  wire [3:0] chan = cmd_word[CH_HI:CH_LO];
  wire [CODE_W-1:0] cmd_data = cmd_word[CODE_W-1:0];
  wire upd_all = (async_update_n_fall && cs_s) || upd_pend_ff
    || (exec && opcode == OP_UPD_ALL);
  wire dither_mode = ctrl_ff[CTRL_DITHER];

  // serial shift-in, bit count saturates so long words still fail
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sck_q_ff <= 1'b0;
      cs_q_ff <= 1'b1;
      async_update_n_q_ff <= 1'b1;
      tgp_q_ff <= '0;
    end else begin
      sck_q_ff <= sck_s;
      cs_q_ff <= cs_s;
      async_update_n_q_ff <= async_update_n_s;
      tgp_q_ff <= tgp_s;
    end
  end

  wire [CNT_W-1:0] nxt_cnt = cs_fall ? '0
    : (sck_rise && cnt_ff != CNT_MAX) ? cnt_ff + 6'd1 : cnt_ff;
  wire [SR_W-1:0] nxt_sr = sck_rise ? {sr_ff[SR_W-2:0], sdi_s} : sr_ff;

  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      cnt_ff <= '0;
      sr_ff <= '0;
      last_word_ff <= '0;
      upd_pend_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      sr_ff <= nxt_sr;
      if (exec) begin
        last_word_ff <= cmd_word;
      end
      // one cycle later so the command's own write lands first
      upd_pend_ff <= cs_rise && !async_update_n_s;
    end
  end

  // serial output: echoes the previous command word msb first
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      tx_ff <= '0;
      sdo_ff <= 1'b0;
      sdo_oe_ff <= 1'b0;
    end else begin
      sdo_oe_ff <= !cs_s;
      if (cs_fall) begin
        tx_ff <= {8'h00, last_word_ff};
        sdo_ff <= 1'b0;
      end else if (sck_fall) begin
        tx_ff <= {tx_ff[SR_W-2:0], 1'b0};
        sdo_ff <= tx_ff[SR_W-1];
      end
    end
  end

  // fault: a new cause in the release cycle wins
  wire fault_set = temp_s || word_err;
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      fault_ff <= 1'b0;
    end else if (fault_set) begin
      fault_ff <= 1'b1;
    end else if (cs_rise) begin
      fault_ff <= 1'b0;
    end
  end

  // per channel registers
  genvar i;
  generate
    for (i = 0; i < CHANNELS; i++) begin : g_ch
      wire hit = exec && (chan == 4'(i));
      wire tgl_on = tgl_en_ff[i];
      wire pin_rise = tgp_rise[i % TGP_N] && tgl_on;
      wire pin_fall = tgp_fall[i % TGP_N] && tgl_on;
      always_ff @(posedge clk_i) begin
        if (soft_rst) begin
          in_a_ff[i] <= '0;
          in_b_ff[i] <= '0;
          dac_ff[i] <= '0;
          span_ff[i] <= SPAN_0_5V;
          phase_ff[i] <= '0;
        end else begin
          if (hit && (opcode == OP_WR_A || opcode == OP_WR_A_UPD)) begin
            in_a_ff[i] <= cmd_data;
          end
          if (hit && opcode == OP_WR_B) begin
            in_b_ff[i] <= cmd_data;
          end
          if (hit && opcode == OP_SPAN) begin
            span_ff[i] <= cmd_data[SPAN_W-1:0];
          end
          if (hit && opcode == OP_WR_A_UPD) begin
            dac_ff[i] <= cmd_data;
          end else if (upd_all) begin
            dac_ff[i] <= in_a_ff[i];
          end else if (!dither_mode && pin_fall) begin
            dac_ff[i] <= in_a_ff[i];
          end else if (!dither_mode && pin_rise) begin
            dac_ff[i] <= in_b_ff[i];
          end
          if (dither_mode && pin_rise) begin
            phase_ff[i] <= phase_ff[i] + 2'd1;
          end
        end
      end
      assign dac_code_o[i*CODE_W +: CODE_W] = dac_ff[i];
      assign span_o[i*SPAN_W +: SPAN_W] = span_ff[i];
      assign dither_phase_o[i*PHASE_W +: PHASE_W] = phase_ff[i];
    end
  endgenerate

  // apb slave: one wait-free access, answer registered in setup
  wire apb_setup = psel_i && !penable_i;
  wire apb_wr = psel_i && penable_i && pready_ff && pwrite_i;
  wire sel_ctrl = paddr_i == ADDR_CTRL;
  wire sel_tgl = paddr_i == ADDR_TGL_EN;
  wire sel_last = paddr_i == ADDR_LAST_WORD;
  wire sel_stat = paddr_i == ADDR_STATUS;
  wire sel_istat = paddr_i == ADDR_IRQ_STAT;
  wire sel_iclr = paddr_i == ADDR_IRQ_CLR;
  wire sel_ien = paddr_i == ADDR_IRQ_EN;
  wire mapped = sel_ctrl || sel_tgl || sel_last || sel_stat || sel_istat
    || sel_iclr || sel_ien;
  wire [31:0] rd_mux = sel_ctrl ? {24'h000000, ctrl_ff}
    : sel_tgl ? {16'h0000, tgl_en_ff}
    : sel_last ? {8'h00, last_word_ff}
    : sel_stat ? {24'h000000, cnt_ff, clr_act, fault_ff}
    : sel_istat ? {28'h0000000, irq_stat_ff}
    : sel_ien ? {28'h0000000, irq_en_ff}
    : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= apb_setup;
      pslverr_ff <= apb_setup && !mapped;
      if (apb_setup && !pwrite_i) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  // software bits; pins holding toggle low and enables zero are the user's job
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      ctrl_ff <= CTRL_RESET;
      tgl_en_ff <= '0;
      irq_en_ff <= '0;
    end else if (apb_wr) begin
      if (sel_ctrl) begin
        ctrl_ff <= pwdata_i[CTRL_W-1:0];
      end
      if (sel_tgl) begin
        tgl_en_ff <= pwdata_i[CHANNELS-1:0];
      end
      if (sel_ien) begin
        irq_en_ff <= pwdata_i[IRQ_W-1:0];
      end
    end
  end

  // sticky events; a set in the clear cycle wins
  wire [IRQ_W-1:0] irq_ev = {word_err, fault_set && !fault_ff, upd_all, exec};
  wire [IRQ_W-1:0] irq_clr = (apb_wr && sel_iclr) ? pwdata_i[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_ev;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      irq_stat_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= |(nxt_irq_stat & irq_en_ff);
    end
  end

  // monitor and reference controls straight from the control register
  assign mux_sel_o = ctrl_ff[CTRL_MUX_LO +: MUX_W];
  assign mux_oe_o = ctrl_ff[CTRL_MUX_EN];
  assign ref_int_en_o = ctrl_ff[CTRL_REF_EXT] == 1'b0;
  // reference switch itself is analog; only the enable level leaves here

  assign sdo_o = sdo_ff;
  assign sdo_oe_o = sdo_oe_ff;
  assign fault_o = 1'b0;
  assign fault_oe_o = fault_ff;
  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign irq_o = irq_ff;
endmodule

//--- verilog/mdc_pkg.sv
// constants for the multichannel dac serial update controller
// assumes one 40 MHz clock and an apb slave port for configuration
package mdc_pkg;
  localparam int CHANNELS = 16;
  localparam int CODE_W = 16;
  localparam int SPAN_W = 3;
  localparam int PHASE_W = 2;
  localparam int TGP_N = 3;
  localparam int SYNC_N = 9;
  localparam int SR_W = 32;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] WORD_SHORT = 6'd24;
  localparam logic [CNT_W-1:0] WORD_LONG = 6'd32;
  localparam logic [CNT_W-1:0] CNT_MAX = 6'h3f;
  // command word: [23:20] opcode, [19:16] channel, [15:0] data
  localparam int CMD_HI = 23;
  localparam int CMD_LO = 20;
  localparam int CH_HI = 19;
  localparam int CH_LO = 16;
  localparam logic [3:0] OP_WR_A = 4'h0;
  localparam logic [3:0] OP_WR_B = 4'h1;
  localparam logic [3:0] OP_WR_A_UPD = 4'h2;
  localparam logic [3:0] OP_UPD_ALL = 4'h3;
  localparam logic [3:0] OP_SPAN = 4'h4;
  localparam logic [SPAN_W-1:0] SPAN_0_5V = 3'h0;
  // apb map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TGL_EN = 8'h04;
  localparam logic [7:0] ADDR_LAST_WORD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h18;
  localparam int CTRL_DITHER = 0;
  localparam int CTRL_REF_EXT = 1;
  localparam int CTRL_MUX_EN = 2;
  localparam int CTRL_MUX_LO = 3;
  localparam int MUX_W = 5;
  localparam int CTRL_W = 8;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
  localparam int IRQ_W = 4;
  localparam int IRQ_EXEC = 0;
  localparam int IRQ_UPD = 1;
  localparam int IRQ_FAULT = 2;
  localparam int IRQ_WERR = 3;
  // synchroniser bit positions
  localparam int S_SCK = 0;
  localparam int S_SDI = 1;
  localparam int S_CS = 2;
  localparam int S_ASYNC_UPDATE_N = 3;
  localparam int S_CLR = 4;
  localparam int S_TEMP = 5;
  localparam int S_TGP = 6;
endpackage

//--- verilog/mdc_sync.sv
// two-flop synchroniser, one stage pair per bit
// assumes inputs asynchronous to clk_i; reset value given per bit
`timescale 1ns/1ps
module mdc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
          meta_ff[i] <= INIT[i];
          sync_ff[i] <= INIT[i];
        end else begin
          meta_ff[i] <= async_i[i];
          sync_ff[i] <= meta_ff[i];
        end
      end
    end
  endgenerate
  assign sync_o = sync_ff;
endmodule
